// ### shpi_pkg.sv
// shared constants and types for the storage card host pin interface
package shpi_pkg;
  localparam int ADDR_W       = 11;
  localparam int DATA_W       = 16;
  localparam int TASK_SEL_W   = 3;
  localparam int INIT_CYCLES  = 64;    // internal initialisation length after reset
  localparam int WAIT_CYCLES  = 2;     // cycle-extend length per access
  localparam int HOST_DIV     = 4;     // host strobe phase length in clocks
  localparam logic [7:0] ATTR_RESET  = 8'h00;
  localparam logic [7:0] TASK_RESET  = 8'h00;
  localparam logic [7:0] ALT_STATUS_IDX = 8'h06;
  localparam logic [7:0] INVALID_BYTE   = 8'hff;

  typedef enum logic [1:0] {
    SHPI_MODE_MEM  = 2'b00,
    SHPI_MODE_IO   = 2'b01,
    SHPI_MODE_DISK = 2'b11
  } shpi_mode_t;
endpackage

// ### shpi_if.sv
// pin-level interface between the card and the host socket controller
`timescale 1ns/1ps
interface shpi_if;
  logic [10:0] addr;
  logic [15:0] host_data;
  logic        host_data_oe;
  logic [15:0] card_data;
  logic [1:0]  card_data_oe;
  logic        even_byte_select_n;
  logic        odd_byte_select_n;
  logic        disk_mode_select_n;
  logic        mem_write_strobe_n;
  logic        io_read_strobe_n;
  logic        io_write_strobe_n;
  logic        attr_select_n;
  logic        hw_reset;
  logic        master_slave_select_n;
  logic        ready_busy_n;
  logic        wide_transfer_indicator_n;
  logic        wait_n;
  logic        input_acknowledge_n;
  logic        battery_status_1;
  logic        battery_status_2;
  logic        card_detect_1_n;
  logic        card_detect_2_n;
  logic        voltage_sense_1_n;
  logic        drive_active_slave_present_n;
  logic        drive_active_slave_present_oe;
  logic        passed_diagnostic_n;
  logic        passed_diagnostic_oe;

  modport card (
    input  addr, host_data, host_data_oe, even_byte_select_n, odd_byte_select_n,
           disk_mode_select_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n,
           attr_select_n, hw_reset, master_slave_select_n,
    output card_data, card_data_oe, ready_busy_n, wide_transfer_indicator_n, wait_n,
           input_acknowledge_n, battery_status_1, battery_status_2, card_detect_1_n,
           card_detect_2_n, voltage_sense_1_n, drive_active_slave_present_n,
           drive_active_slave_present_oe, passed_diagnostic_n, passed_diagnostic_oe
  );
  modport host (
    output addr, host_data, host_data_oe, even_byte_select_n, odd_byte_select_n,
           disk_mode_select_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n,
           attr_select_n, hw_reset, master_slave_select_n,
    input  card_data, card_data_oe, ready_busy_n, wide_transfer_indicator_n, wait_n,
           input_acknowledge_n, battery_status_1, battery_status_2, card_detect_1_n,
           card_detect_2_n, voltage_sense_1_n, drive_active_slave_present_n,
           drive_active_slave_present_oe, passed_diagnostic_n, passed_diagnostic_oe
  );
endinterface

// ### shpi_sync.sv
// two-flop synchroniser bank for host pins
`timescale 1ns/1ps
module shpi_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

// ### shpi_card.sv
// card end: decodes host pins, holds task and attribute bytes, drives status pins
//
// Functional notes
// - eleven-bit address, bit 0 ignored for words
// - disk mode uses address bits 0..2 only
// - bit 0 even byte lsb, bit 8 odd
// - even/odd selects gate byte lanes outside disk mode; disk reads use the even lane only
// - disk mode: odd select picks control registers
// - grounded mode select enters disk mode
// - host ties memory write high in disk
// - io strobes ignored until io configured, used in disk mode
// - io mode: request pin low when servicing
// - memory mode: busy low during initialisation
// - disk mode: request pin active-high interrupt
// - memory mode: write protect held low
// - io mode: wide indicator on word task accesses
// - host drives attribute select per space
// - attribute even only, odd bytes invalid
// - battery and audio outputs held high
// - reset clears registers, ready goes high
// - cycle-extend low lengthens access
// - input acknowledge on io reads only
// - grounded select means master in disk
// - voltage sense low, card detects grounded
// - handshake pins in disk mode
`timescale 1ns/1ps
module shpi_card #(
  parameter int INIT_LEN = shpi_pkg::INIT_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  shpi_if.card      bus,
  input  wire logic i_io_configure,
  input  wire logic i_service_request,
  input  wire logic i_drive_active,
  input  wire logic i_diag_passed,
  output logic      o_is_master,
  output logic [1:0] o_mode,
  output logic      o_busy
);
  // ----------------------------------------------------------------
  // synchronisation of host controls
  // ----------------------------------------------------------------
  logic [7:0]  ctl_s;
  logic [10:0] addr_s;
  logic [15:0] wdata_s;
  shpi_sync #(.WIDTH(8), .RESET_VAL(8'hff)) u_sync_ctl (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({bus.even_byte_select_n, bus.odd_byte_select_n, bus.disk_mode_select_n,
                bus.mem_write_strobe_n, bus.io_read_strobe_n, bus.io_write_strobe_n,
                bus.attr_select_n, ~bus.hw_reset}),
    .o_sync   (ctl_s)
  );
  shpi_sync #(.WIDTH(27), .RESET_VAL(27'h0)) u_sync_dat (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({bus.addr, bus.host_data}),
    .o_sync   ({addr_s, wdata_s})
  );
  logic even_sel_n, odd_sel_n, mode_n, we_n, io_rd_n, io_wr_n, reg_n, hwrst_n;
  assign {even_sel_n, odd_sel_n, mode_n, we_n, io_rd_n, io_wr_n, reg_n, hwrst_n} = ctl_s;

  // ----------------------------------------------------------------
  // mode, reset and initialisation
  // ----------------------------------------------------------------
  logic       disk, io_cfg, we_q, io_write_strobe_n_q, strobe_prev;
  logic [7:0] init_cnt;
  logic [7:0] attr_mem [0:7];
  logic [7:0] task_mem [0:7];

  // disk mode is latched from the mode select while the host holds reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      disk   <= 1'b0;
      io_cfg <= 1'b0;
    end else if (!hwrst_n) begin
      disk   <= ~mode_n;
      io_cfg <= 1'b0;
    end else if (i_io_configure && !disk) begin
      io_cfg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      init_cnt <= 8'h00;
    end else if (!hwrst_n) begin
      init_cnt <= 8'h00;
    end else if (init_cnt != 8'(INIT_LEN)) begin
      init_cnt <= init_cnt + 8'h01;
    end
  end
  logic initialising;
  assign initialising = (init_cnt != 8'(INIT_LEN)) || !hwrst_n;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic       io_rd, io_wr, mem_rd, mem_wr, word, odd_only, any_wr, any_rd;
  logic [2:0] idx;
  logic       use_io;
  assign use_io  = io_cfg || disk;
  assign io_rd   = use_io && !io_rd_n;
  assign io_wr   = use_io && !io_wr_n;
  assign mem_rd  = !disk && !mode_n && !initialising;
  assign mem_wr  = !disk && !we_n && !initialising;
  assign word    = !even_sel_n && !odd_sel_n && !disk;
  assign odd_only = even_sel_n && !odd_sel_n;
  // disk: address bits above 2 are held low by the host, odd select reaches control regs
  assign idx = disk ? (odd_only ? 3'(shpi_pkg::ALT_STATUS_IDX) : addr_s[2:0])
                    : {addr_s[3:2], word ? 1'b0 : (odd_only | addr_s[0])};
  assign any_rd  = io_rd || mem_rd;
  assign any_wr  = io_wr || mem_wr;

  // ----------------------------------------------------------------
  // register storage; written once per strobe edge
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= any_wr;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_regs
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          attr_mem[g] <= shpi_pkg::ATTR_RESET;
          task_mem[g] <= shpi_pkg::TASK_RESET;
        end else if (!hwrst_n) begin
          attr_mem[g] <= shpi_pkg::ATTR_RESET;
          task_mem[g] <= shpi_pkg::TASK_RESET;
        end else if (any_wr && !strobe_prev) begin
          if (!reg_n && mem_wr && !even_sel_n && !addr_s[0] && g == {1'b0, addr_s[3:2]}) begin
            attr_mem[g] <= wdata_s[7:0];
          end else if ((reg_n || io_wr) && g == idx) begin
            task_mem[g] <= (odd_only && !disk) ? wdata_s[15:8] : wdata_s[7:0];
          end else if ((reg_n || io_wr) && word && g == idx + 3'h1) begin
            task_mem[g] <= wdata_s[15:8];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data and byte-lane enables
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus.card_data    <= 16'h0000;
      bus.card_data_oe <= 2'b00;
    end else if (!any_rd || (even_sel_n && odd_sel_n)) begin
      bus.card_data_oe <= 2'b00;
    end else if (!reg_n && mem_rd) begin
      // attribute bytes exist at even addresses only
      bus.card_data <= {shpi_pkg::INVALID_BYTE,
                        addr_s[0] && !word ? shpi_pkg::INVALID_BYTE
                                           : attr_mem[{1'b0, addr_s[3:2]}]};
      bus.card_data_oe <= {!odd_sel_n, !even_sel_n};
    end else if (word) begin
      bus.card_data    <= {task_mem[idx + 3'h1], task_mem[idx]};
      bus.card_data_oe <= 2'b11;
    end else if (odd_only && !disk) begin
      bus.card_data    <= {task_mem[idx], 8'h00};
      bus.card_data_oe <= 2'b10;
    end else begin
      bus.card_data    <= {8'h00, task_mem[idx]};
      bus.card_data_oe <= 2'b01;
    end
  end

  // ----------------------------------------------------------------
  // status pins
  // ----------------------------------------------------------------
  logic [1:0] wait_cnt;
  logic       rd_prev;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_cnt <= 2'h0;
      rd_prev  <= 1'b0;
    end else begin
      rd_prev  <= any_rd || any_wr;
      if ((any_rd || any_wr) && !rd_prev) begin
        wait_cnt <= 2'(shpi_pkg::WAIT_CYCLES);
      end else if (wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus.ready_busy_n              <= 1'b0;
      bus.wide_transfer_indicator_n <= 1'b1;
      bus.wait_n                    <= 1'b1;
      bus.input_acknowledge_n       <= 1'b1;
    end else begin
      // one pin: ready/busy, service request or disk interrupt
      if (disk) begin
        bus.ready_busy_n <= i_service_request;
      end else if (io_cfg) begin
        bus.ready_busy_n <= ~i_service_request;
      end else begin
        bus.ready_busy_n <= ~initialising;
      end
      if (disk) begin
        bus.wide_transfer_indicator_n <= !(idx == 3'h0 && !even_sel_n);
      end else if (io_cfg) begin
        bus.wide_transfer_indicator_n <= !(word && (io_rd || io_wr));
      end else begin
        bus.wide_transfer_indicator_n <= 1'b0;
      end
      bus.wait_n <= ((any_rd || any_wr) && !rd_prev) ? 1'b0 : (wait_cnt <= 2'h1);
      bus.input_acknowledge_n <= !(io_cfg && !disk && io_rd
                                   && !(even_sel_n && odd_sel_n));
    end
  end

  // fixed pins and disk handshake; battery lines double as audio and are held high
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus.battery_status_1              <= 1'b1;
      bus.battery_status_2              <= 1'b1;
      bus.card_detect_1_n               <= 1'b0;
      bus.card_detect_2_n               <= 1'b0;
      bus.voltage_sense_1_n             <= 1'b0;
      bus.drive_active_slave_present_n  <= 1'b1;
      bus.drive_active_slave_present_oe <= 1'b0;
      bus.passed_diagnostic_n           <= 1'b1;
      bus.passed_diagnostic_oe          <= 1'b0;
      o_is_master                       <= 1'b0;
      o_mode                            <= 2'b00;
      o_busy                            <= 1'b1;
    end else begin
      bus.battery_status_1  <= 1'b1;
      bus.battery_status_2  <= 1'b1;
      bus.card_detect_1_n   <= 1'b0;
      bus.card_detect_2_n   <= 1'b0;
      bus.voltage_sense_1_n <= 1'b0;
      o_is_master <= disk && !bus.master_slave_select_n;
      // slave announces itself, master or slave reports activity
      bus.drive_active_slave_present_n  <= ~i_drive_active;
      bus.drive_active_slave_present_oe <= disk && i_drive_active;
      bus.passed_diagnostic_n           <= ~i_diag_passed;
      bus.passed_diagnostic_oe          <= disk && !o_is_master && i_diag_passed;
      o_mode <= disk ? shpi_pkg::SHPI_MODE_DISK
                     : (io_cfg ? shpi_pkg::SHPI_MODE_IO : shpi_pkg::SHPI_MODE_MEM);
      o_busy <= initialising;
    end
  end
endmodule

// ### shpi_host.sv
// host end: runs single register accesses over the card pins
`timescale 1ns/1ps
module shpi_host (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  shpi_if.host             bus,
  input  wire logic        i_disk_mode,
  input  wire logic        i_master_strap,
  input  wire logic        i_card_reset,
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic        i_io,
  input  wire logic        i_attr,
  input  wire logic [1:0]  i_lanes,
  input  wire logic [10:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_busy,
  output logic             o_done,
  output logic [15:0]      o_rdata
);
  typedef enum logic [1:0] {
    SHPI_H_IDLE   = 2'b00,
    SHPI_H_SETUP  = 2'b01,
    SHPI_H_STROBE = 2'b11,
    SHPI_H_HOLD   = 2'b10
  } shpi_hstate_t;
  shpi_hstate_t state;
  logic [2:0]   cnt;
  logic         wr, io;

  // ----------------------------------------------------------------
  // access sequencer; waits on ready and the cycle-extend pin
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= SHPI_H_IDLE;
      cnt   <= 3'h0;
      wr    <= 1'b0;
      io    <= 1'b0;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      unique case (state)
        SHPI_H_IDLE: begin
          // no access while the card reports busy in memory mode
          if (i_req && !i_card_reset && (bus.ready_busy_n || i_io || i_disk_mode)) begin
            state  <= SHPI_H_SETUP;
            wr     <= i_write;
            io     <= i_io || i_disk_mode;
            o_busy <= 1'b1;
            cnt    <= 3'(shpi_pkg::HOST_DIV);
          end
        end
        SHPI_H_SETUP: begin
          cnt <= cnt - 3'h1;
          if (cnt == 3'h1) begin
            state <= SHPI_H_STROBE;
            cnt   <= 3'(shpi_pkg::HOST_DIV);
          end
        end
        SHPI_H_STROBE: begin
          if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
          end else if (bus.wait_n) begin
            o_rdata <= bus.card_data;
            state   <= SHPI_H_HOLD;
            cnt     <= 3'(shpi_pkg::HOST_DIV);
          end
        end
        SHPI_H_HOLD: begin
          cnt <= cnt - 3'h1;
          if (cnt == 3'h1) begin
            state  <= SHPI_H_IDLE;
            o_done <= 1'b1;
            o_busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic active, strobe;
  assign active = state != SHPI_H_IDLE;
  assign strobe = state == SHPI_H_STROBE;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus.addr                  <= 11'h000;
      bus.host_data             <= 16'h0000;
      bus.host_data_oe          <= 1'b0;
      bus.even_byte_select_n    <= 1'b1;
      bus.odd_byte_select_n     <= 1'b1;
      bus.disk_mode_select_n    <= 1'b1;
      bus.mem_write_strobe_n    <= 1'b1;
      bus.io_read_strobe_n      <= 1'b1;
      bus.io_write_strobe_n     <= 1'b1;
      bus.attr_select_n         <= 1'b1;
      bus.hw_reset              <= 1'b1;
      bus.master_slave_select_n <= 1'b1;
    end else begin
      // high address bits grounded in disk mode
      bus.addr <= i_disk_mode ? {8'h00, i_addr[2:0]} : i_addr;
      bus.host_data    <= i_wdata;
      bus.host_data_oe <= active && wr;
      bus.even_byte_select_n <= !(active && i_lanes[0]);
      bus.odd_byte_select_n  <= !(active && i_lanes[1]);
      // mode select doubles as the memory read strobe
      bus.disk_mode_select_n <= i_disk_mode ? 1'b0 : !(strobe && !wr && !io);
      bus.mem_write_strobe_n <= i_disk_mode ? 1'b1 : !(strobe && wr && !io);
      bus.io_read_strobe_n   <= !(strobe && !wr && io);
      bus.io_write_strobe_n  <= !(strobe && wr && io);
      bus.attr_select_n      <= i_disk_mode ? 1'b1 : !(active && i_attr);
      bus.hw_reset           <= i_card_reset;
      bus.master_slave_select_n <= !i_master_strap;
    end
  end
endmodule

// ### shpi_asserts.sv
// pin-level checker for the card/host interface
`timescale 1ns/1ps
module shpi_asserts #(
  parameter int INIT_LEN = shpi_pkg::INIT_CYCLES
) (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [10:0] addr,
  input wire logic [1:0]  card_data_oe,
  input wire logic        even_byte_select_n,
  input wire logic        odd_byte_select_n,
  input wire logic        disk_mode_select_n,
  input wire logic        io_read_strobe_n,
  input wire logic        hw_reset,
  input wire logic        ready_busy_n,
  input wire logic        wide_transfer_indicator_n,
  input wire logic        wait_n,
  input wire logic        input_acknowledge_n,
  input wire logic        battery_status_2,
  input wire logic        card_detect_1_n,
  input wire logic        card_detect_2_n,
  input wire logic        voltage_sense_1_n
);
  logic       disk_lat;
  logic       mem_init;
  logic [7:0] since_rst;
  logic       sel_any;

  // --------------------------------
  // helper state
  // --------------------------------
  // mode is latched while card reset is high, as the card does
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      disk_lat <= 1'b0;
      mem_init <= 1'b1;
    end else if (hw_reset) begin
      disk_lat <= !disk_mode_select_n;
      mem_init <= disk_mode_select_n;
    end else if (ready_busy_n) begin
      mem_init <= 1'b0;
    end
  end

  // cycles since card reset fell; saturates so it never wraps
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      since_rst <= 8'h00;
    end else if (hw_reset) begin
      since_rst <= 8'h00;
    end else if (since_rst != 8'hff) begin
      since_rst <= since_rst + 8'h01;
    end
  end

  assign sel_any = !even_byte_select_n || !odd_byte_select_n;

  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  fixed_pins_a: assert property (
      !card_detect_1_n && !card_detect_2_n && !voltage_sense_1_n)
    else $error("card detect or voltage sense not low");
  init_busy_a: assert property (mem_init && since_rst < INIT_LEN |-> !ready_busy_n)
    else $error("ready rose before initialisation ended");
  init_ready_a: assert property (mem_init |-> since_rst <= INIT_LEN + 5)
    else $error("ready did not return after reset");
  wait_short_a: assert property ($fell(wait_n) |-> ##[1:3] wait_n)
    else $error("cycle extend held too long");
  ack_read_a: assert property (!input_acknowledge_n |-> !io_read_strobe_n
      || !$past(io_read_strobe_n) || !$past(io_read_strobe_n, 2)
      || !$past(io_read_strobe_n, 3) || !$past(io_read_strobe_n, 4))
    else $error("input acknowledge without io read");
  disk_ack_a: assert property (disk_lat && since_rst > 4 |-> input_acknowledge_n)
    else $error("input acknowledge driven in disk mode");
  disk_wide_a: assert property (disk_lat && !wide_transfer_indicator_n |->
      addr[2:0] == 3'h0 || $past(addr[2:0], 2) == 3'h0 || $past(addr[2:0], 4) == 3'h0)
    else $error("wide indicator off the data register");
  audio_high_a: assert property (!disk_lat && since_rst > 4 |-> battery_status_2)
    else $error("battery or audio output low");
  select_gates_a: assert property (|card_data_oe |-> sel_any || $past(sel_any)
      || $past(sel_any, 2) || $past(sel_any, 3) || $past(sel_any, 4))
    else $error("card drives data while deselected");

  cover property ($rose(ready_busy_n));
  cover property (!input_acknowledge_n);
  cover property (disk_lat && !wide_transfer_indicator_n);
  cover property (!wait_n);
endmodule

// ### storage_card_host_pin_interface_tb.sv
// self-checking bench: host end and card end joined through the pin interface
`timescale 1ns/1ps
module storage_card_host_pin_interface_tb;
  localparam int INIT = 8;
  logic        i_clk, i_resetn, cfg, srv, dact, diag, is_m, cbusy;
  logic        disk, strap, crst, req, wr, io, at, hbusy, done;
  logic [1:0]  mode, ln;
  logic [2:0]  seen;
  logic [10:0] a;
  logic [15:0] wd, rd, got;
  int          n_fail, n_checks;

  shpi_if bus ();
  shpi_card #(.INIT_LEN(INIT)) i_shpi_card (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus.card),
    .i_io_configure(cfg), .i_service_request(srv), .i_drive_active(dact),
    .i_diag_passed(diag), .o_is_master(is_m), .o_mode(mode), .o_busy(cbusy));
  shpi_host i_shpi_host (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus.host), .i_disk_mode(disk),
    .i_master_strap(strap), .i_card_reset(crst), .i_req(req), .i_write(wr), .i_io(io),
    .i_attr(at), .i_lanes(ln), .i_addr(a), .i_wdata(wd), .o_busy(hbusy), .o_done(done),
    .o_rdata(rd));
  shpi_asserts #(.INIT_LEN(INIT)) i_shpi_asserts (.i_clk(i_clk), .i_resetn(i_resetn),
    .addr(bus.addr), .card_data_oe(bus.card_data_oe),
    .even_byte_select_n(bus.even_byte_select_n), .odd_byte_select_n(bus.odd_byte_select_n),
    .disk_mode_select_n(bus.disk_mode_select_n), .io_read_strobe_n(bus.io_read_strobe_n),
    .hw_reset(bus.hw_reset), .ready_busy_n(bus.ready_busy_n),
    .wide_transfer_indicator_n(bus.wide_transfer_indicator_n), .wait_n(bus.wait_n),
    .input_acknowledge_n(bus.input_acknowledge_n), .battery_status_2(bus.battery_status_2),
    .card_detect_1_n(bus.card_detect_1_n), .card_detect_2_n(bus.card_detect_2_n),
    .voltage_sense_1_n(bus.voltage_sense_1_n));

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // --------------------------------
  // tasks
  // --------------------------------
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one host access; seen collects wide, wait and acknowledge activity
  task automatic acc(input logic w, i, t, input logic [1:0] l, input logic [10:0] ad,
                     input logic [15:0] d);
    int k;
    wr = w; io = i; at = t; ln = l; a = ad; wd = d; req = 1'b1;
    seen = 3'b000;
    k = 0;
    do begin
      tick();
      k++;
    end while (hbusy !== 1'b1 && k < 50);
    req = 1'b0;
    while (done !== 1'b1 && k < 200) begin
      seen |= ~{bus.wide_transfer_indicator_n, bus.wait_n, bus.input_acknowledge_n};
      tick();
      k++;
    end
    got = rd;
    if (k >= 200) begin
      n_fail++;
      end_sim();
    end
  endtask

  // card reset pulse, then wait until the card is usable
  task automatic card_reset(input logic dm);
    int k;
    disk = dm; crst = 1'b1;
    repeat (6) tick();
    crst = 1'b0;
    tick();
    if (!dm) chk({15'h0, bus.ready_busy_n}, 16'h0000);
    k = 0;
    do begin
      tick();
      k++;
    end while ((cbusy !== 1'b0 || (!dm && bus.ready_busy_n !== 1'b1)) && k < 100);
    if (k >= 100) begin
      n_fail++;
      end_sim();
    end
  endtask

  // --------------------------------
  // test sequence
  // --------------------------------
  initial begin
    n_fail = 0; n_checks = 0; i_resetn = 1'b0; cfg = 0; srv = 0; dact = 0; diag = 0;
    disk = 0; strap = 1; crst = 0; req = 0; wr = 0; io = 0; at = 0; ln = 0; a = 0; wd = 0;
    repeat (3) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    card_reset(1'b0);
    chk({9'h0, bus.battery_status_1, bus.battery_status_2, bus.wide_transfer_indicator_n,
         bus.input_acknowledge_n, bus.card_detect_1_n, bus.card_detect_2_n,
         bus.voltage_sense_1_n}, 16'h0068);
    acc(1, 0, 0, 2'b11, 11'h000, 16'ha55a);
    acc(0, 0, 0, 2'b11, 11'h001, 16'h0000);
    chk(got, 16'ha55a);
    chk({13'h0, seen}, 16'h0006);
    acc(1, 0, 0, 2'b10, 11'h002, 16'hc300);
    acc(1, 0, 0, 2'b01, 11'h002, 16'h003c);
    acc(0, 0, 0, 2'b11, 11'h002, 16'h0000);
    chk(got, 16'hc33c);
    acc(1, 0, 1, 2'b01, 11'h004, 16'h0012);
    acc(0, 0, 1, 2'b11, 11'h004, 16'h0000);
    chk({8'h0, got[7:0]}, 16'h0012);
    acc(0, 0, 1, 2'b01, 11'h005, 16'h0000);
    chk({8'h0, got[7:0]}, {8'h0, shpi_pkg::INVALID_BYTE});
    acc(1, 1, 0, 2'b01, 11'h004, 16'h0077);
    acc(0, 0, 0, 2'b01, 11'h004, 16'h0000);
    chk({8'h0, got[7:0]}, {8'h0, shpi_pkg::TASK_RESET});
    $display("test memory mode done");
    cfg = 1'b1;
    repeat (4) tick();
    chk({14'h0, mode}, {14'h0, shpi_pkg::SHPI_MODE_IO});
    acc(1, 1, 0, 2'b11, 11'h004, 16'h6677);
    acc(0, 1, 0, 2'b11, 11'h004, 16'h0000);
    chk(got, 16'h6677);
    chk({13'h0, seen}, 16'h0007);
    srv = 1'b1;
    repeat (4) tick();
    chk({15'h0, bus.ready_busy_n}, 16'h0000);
    srv = 1'b0;
    repeat (4) tick();
    chk({15'h0, bus.ready_busy_n}, 16'h0001);
    $display("test io mode done");
    cfg = 1'b0; strap = 1'b0;
    card_reset(1'b1);
    chk({13'h0, mode, is_m}, {13'h0, shpi_pkg::SHPI_MODE_DISK, 1'b0});
    acc(0, 1, 0, 2'b01, 11'h003, 16'h0000);
    chk({8'h0, got[7:0]}, {8'h0, shpi_pkg::TASK_RESET});
    chk({13'h0, seen & 3'b101}, 16'h0000);
    acc(1, 1, 0, 2'b10, 11'h000, 16'h2121);
    acc(0, 1, 0, 2'b01, 11'h006, 16'h0000);
    chk({8'h0, got[7:0]}, 16'h0021);
    acc(0, 1, 0, 2'b01, 11'h000, 16'h0000);
    chk({13'h0, seen & 3'b101}, 16'h0004);
    chk({14'h0, bus.mem_write_strobe_n, bus.attr_select_n}, 16'h0003);
    srv = 1'b1; dact = 1'b1; diag = 1'b1;
    repeat (4) tick();
    chk({11'h0, bus.ready_busy_n, bus.drive_active_slave_present_n,
         bus.drive_active_slave_present_oe, bus.passed_diagnostic_n,
         bus.passed_diagnostic_oe}, 16'h0015);
    srv = 1'b0;
    repeat (4) tick();
    chk({15'h0, bus.ready_busy_n}, 16'h0000);
    strap = 1'b1;
    repeat (4) tick();
    chk({14'h0, is_m, bus.passed_diagnostic_oe}, 16'h0002);
    $display("test disk mode done");
    card_reset(1'b0);
    chk({14'h0, mode}, {14'h0, shpi_pkg::SHPI_MODE_MEM});
    $display("test return to memory done");
    end_sim();
  end
endmodule
